// File: verilog/acc_ctrl.sv
// Purpose: computation control of a converter: mode, shift, clear, error select, stop on threshold
// Assumes: one 250 MHz clock, byte registers on a plain port, read data one cycle late
// Notes:   control register a holds mode, clear, shift and source select; b holds error select and stop bit
//
// Contract
// [RULE_01] accumulate/average modes shift accumulator right
// [RULE_02] basic and code seven ignore shift
// [RULE_03] clear command clears accumulator, counter, overflow
// [RULE_04] hardware drops clear bit when done
// [RULE_05] mode field selects five modes
// [RULE_06] software sets repeat count two^shift
// [RULE_07] software avoids shift codes zero, seven
// [RULE_08] single-sample error select table
// [RULE_09] double-sample codes one, two subtract previous
// [RULE_10] double-sample, select clear: error every second
// [RULE_11] continuous, stop bit set: clear go on threshold
// [RULE_12] continuous, stop bit clear: never clear go
// [RULE_13] not continuous: stop bit ignored
// [RULE_14] conversion start copies filtered or result to previous
// [RULE_15] reserved codes give no computation
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl
   import acc_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // register port
   input  wire logic [15:0]       reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata_q,
   // converter data and events
   input  wire acc_data_s         data_in,
   input  wire acc_evt_s          evt_in,
   input  wire logic [ACC_AW-1:0] accum_raw,
   // computation outputs
   output logic      [ACC_AW-1:0] accumulator_value_q,
   output logic      [ACC_DW-1:0] previous_result_q,
   output logic      [ACC_DW:0]   error_value_q,
   output logic                   error_valid_q,
   output logic                   accum_clear_q,
   output logic                   go_clear_q,
   output logic                   retrigger_q,
   output logic      [2:0]        operating_mode_q
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]            ctrl_a_q;
   logic [7:0]            ctrl_b_q;
   logic [3:0]            clr_cnt_q;
   logic                  pair_q;
   logic [2:0]            mode;
   logic [2:0]            shift_select;
   logic [2:0]            error_sel_a;
   logic                  previous_source_select;
   logic                  stop_on_irq;
   logic                  wr_a;
   logic                  wr_b;
   logic                  clr_start;
   logic                  mode_defined;
   logic                  error_sel_a_defined;
   logic                  error_sel_a_en;
   logic                  second_sample;
   logic [ACC_DW-1:0]     op_a;
   logic [ACC_DW-1:0]     op_b;
   logic [ACC_DW-1:0]     op_c;
   logic [ACC_DW:0]       diff;
   logic                  error_sel_a_pend_q;

   assign mode                   = ctrl_a_q[ACC_MODE_LSB +: 3];
   assign shift_select           = ctrl_a_q[ACC_SHIFT_LSB +: 3];
   assign previous_source_select = ctrl_a_q[ACC_PREVIOUS_SOURCE_SELECT_BIT];
   assign error_sel_a            = ctrl_b_q[ACC_ERROR_SEL_A_LSB +: 3];
   assign stop_on_irq            = ctrl_b_q[ACC_SOI_BIT];
   assign wr_a                   = reg_wr && (reg_addr == ACC_CTRL_A_OFS);
   assign wr_b                   = reg_wr && (reg_addr == ACC_CTRL_B_OFS);
   assign clr_start              = wr_a && reg_wdata[ACC_CLR_BIT];

   // ----------------------------------------------------------------
   // control register a, clear bit self-clears when clearing ends
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_a_q <= ACC_CTRL_A_RST;
      end else if (wr_a) begin
         ctrl_a_q <= reg_wdata;
      end else if (ctrl_a_q[ACC_CLR_BIT] && clr_cnt_q == 4'h1) begin
         ctrl_a_q[ACC_CLR_BIT] <= 1'b0; // [RULE_04]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clr_cnt_q <= 4'h0;
      end else if (clr_start) begin
         clr_cnt_q <= ACC_CLR_CYCLES;
      end else if (clr_cnt_q != 4'h0) begin
         clr_cnt_q <= clr_cnt_q - 4'h1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         accum_clear_q <= 1'b0;
      end else begin
         accum_clear_q <= clr_start || (clr_cnt_q > 4'h1); // [RULE_03]
      end
   end

   // ----------------------------------------------------------------
   // control register b; bit 7 is unused and reads zero
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_b_q <= ACC_CTRL_B_RST;
      end else if (wr_b) begin
         ctrl_b_q <= {1'b0, reg_wdata[6:0]};
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ACC_CTRL_A_OFS: begin
               reg_rdata_q <= ctrl_a_q;
            end
            ACC_CTRL_B_OFS: begin
               reg_rdata_q <= ctrl_b_q;
            end
            default: begin
               reg_rdata_q <= 8'h00;
            end
         endcase
      end else begin
         reg_rdata_q <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // mode decode and accumulator shift
   // ----------------------------------------------------------------
   always_comb begin
      case (mode)
         ACC_MD_BASIC, ACC_MD_ACCUM, ACC_MD_AVG, ACC_MD_BURST, ACC_MD_LPF: begin
            mode_defined = 1'b1; // [RULE_05]
         end
         default: begin
            mode_defined = 1'b0; // [RULE_15]
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         operating_mode_q <= 3'h0;
      end else begin
         operating_mode_q <= mode_defined ? mode : 3'h0; // [RULE_15]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         accumulator_value_q <= '0;
      end else if (accum_clear_q) begin
         accumulator_value_q <= '0; // [RULE_03]
      end else begin
         case (mode)
            ACC_MD_ACCUM, ACC_MD_AVG, ACC_MD_BURST: begin
               accumulator_value_q <= accum_raw >> shift_select; // [RULE_01]
            end
            default: begin
               accumulator_value_q <= accum_raw; // [RULE_02]
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // previous result capture and sample pairing
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         previous_result_q <= '0;
      end else if (evt_in.conv_start) begin
         previous_result_q <= previous_source_select ? data_in.filtered_value
                                                     : data_in.conversion_result; // [RULE_14]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pair_q <= 1'b0;
      end else if (!evt_in.double_sample_enable || accum_clear_q) begin
         pair_q <= 1'b0;
      end else if (evt_in.conv_done) begin
         pair_q <= ~pair_q;
      end
   end

   assign second_sample = !evt_in.double_sample_enable || previous_source_select || pair_q; // [RULE_10]

   // ----------------------------------------------------------------
   // error operand select
   // ----------------------------------------------------------------
   always_comb begin
      op_a         = data_in.conversion_result;
      op_b         = previous_result_q;
      op_c         = '0;
      error_sel_a_defined = 1'b1;
      case (error_sel_a)
         ACC_ERROR_SEL_A_RES_PREV: begin
            op_b = previous_result_q; // [RULE_08]
         end
         ACC_ERROR_SEL_A_RES_STPT: begin
            op_b = evt_in.double_sample_enable ? previous_result_q : data_in.setpoint_value; // [RULE_09]
            op_c = evt_in.double_sample_enable ? data_in.setpoint_value : '0;
         end
         ACC_ERROR_SEL_A_RES_FLT: begin
            op_b = evt_in.double_sample_enable ? previous_result_q : data_in.filtered_value; // [RULE_09]
            op_c = evt_in.double_sample_enable ? data_in.filtered_value : '0;
         end
         ACC_ERROR_SEL_A_PREV_FLT: begin
            op_a = previous_result_q; // [RULE_08]
            op_b = data_in.filtered_value;
         end
         ACC_ERROR_SEL_A_FLT_STPT: begin
            op_a = data_in.filtered_value; // [RULE_08]
            op_b = data_in.setpoint_value;
         end
         default: begin
            error_sel_a_defined = 1'b0; // [RULE_15]
         end
      endcase
   end

   assign error_sel_a_en = evt_in.conv_done && second_sample && error_sel_a_defined;

   acc_subtract u_sub (
      .clk    (clk),
      .nrst   (nrst),
      .en     (error_sel_a_en),
      .a      (op_a),
      .b      (op_b),
      .c      (op_c),
      .diff_q (diff)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         error_sel_a_pend_q <= 1'b0;
      end else begin
         error_sel_a_pend_q <= error_sel_a_en;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         error_value_q <= '0;
         error_valid_q <= 1'b0;
      end else begin
         error_valid_q <= error_sel_a_pend_q;
         if (error_sel_a_pend_q) begin
            error_value_q <= diff;
         end
      end
   end

   // ----------------------------------------------------------------
   // continuous conversion: stop on threshold or retrigger
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         go_clear_q  <= 1'b0;
         retrigger_q <= 1'b0;
      end else begin
         go_clear_q  <= evt_in.continuous_enable && stop_on_irq && evt_in.threshold_met
                        && evt_in.conv_done; // [RULE_11] [RULE_12] [RULE_13]
         retrigger_q <= evt_in.continuous_enable && evt_in.conv_done
                        && !(stop_on_irq && evt_in.threshold_met); // [RULE_11] [RULE_12]
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_CLR_SELF: assert property (@(posedge clk) disable iff (!nrst) // [RULE_04]
      clr_start |=> ##4 !ctrl_a_q[ACC_CLR_BIT] || wr_a || $past(wr_a))
      else $error("clear bit not released by hardware");
   AST_CLR_ACC: assert property (@(posedge clk) disable iff (!nrst) // [RULE_03]
      clr_start |=> ##1 accumulator_value_q == '0)
      else $error("accumulator not cleared");
   AST_SHIFT: assert property (@(posedge clk) disable iff (!nrst) // [RULE_01]
      (!accum_clear_q && (mode == ACC_MD_AVG)) |=> accumulator_value_q == ($past(accum_raw) >> $past(shift_select)))
      else $error("accumulator shift wrong");
   AST_NOSHIFT: assert property (@(posedge clk) disable iff (!nrst) // [RULE_02]
      (!accum_clear_q && (mode == ACC_MD_BASIC)) |=> accumulator_value_q == $past(accum_raw))
      else $error("shift applied in basic mode");
   AST_PREV: assert property (@(posedge clk) disable iff (!nrst) // [RULE_14]
      (evt_in.conv_start && !previous_source_select) |=> previous_result_q == $past(data_in.conversion_result))
      else $error("previous result not captured");
   AST_GO_CLR: assert property (@(posedge clk) disable iff (!nrst) // [RULE_11]
      (evt_in.continuous_enable && stop_on_irq && evt_in.threshold_met && evt_in.conv_done) |=> go_clear_q && !retrigger_q)
      else $error("go not cleared on threshold");
   AST_NO_GO_CLR: assert property (@(posedge clk) disable iff (!nrst) // [RULE_12]
      $past(!stop_on_irq || !evt_in.continuous_enable) |-> !go_clear_q)
      else $error("go cleared without stop bit");
   AST_PAIR: assert property (@(posedge clk) disable iff (!nrst) // [RULE_10]
      (evt_in.double_sample_enable && !previous_source_select && !pair_q) |=> ##1 !error_valid_q)
      else $error("error computed after first sample");
   AST_RSVD: assert property (@(posedge clk) disable iff (!nrst) // [RULE_15]
      (error_sel_a == 3'b011) |=> !error_sel_a_pend_q)
      else $error("reserved error code computed");
   AST_MODE_OUT: assert property (@(posedge clk) disable iff (!nrst) // [RULE_05]
      mode_defined |=> operating_mode_q == $past(mode))
      else $error("mode output does not follow mode field");
   AST_MODE_RSVD: assert property (@(posedge clk) disable iff (!nrst) // [RULE_15]
      (mode inside {3'b101, 3'b110, 3'b111}) |=> operating_mode_q == 3'h0)
      else $error("reserved mode shown as a mode");
   AST_CLR_HOLD: assert property (@(posedge clk) disable iff (!nrst) // [RULE_03]
      (clr_cnt_q > 4'h1) |=> accum_clear_q)
      else $error("clear dropped while clearing");
   AST_CLR_BIT_HC: assert property (@(posedge clk) disable iff (!nrst) // [RULE_04]
      (ctrl_a_q[ACC_CLR_BIT] && clr_cnt_q == 4'h1 && !wr_a) |=> !ctrl_a_q[ACC_CLR_BIT])
      else $error("clear bit kept after clearing ended");
   AST_RETRIG: assert property (@(posedge clk) disable iff (!nrst) // [RULE_12]
      (evt_in.conv_done && evt_in.continuous_enable && !stop_on_irq) |=> retrigger_q && !go_clear_q)
      else $error("no retrigger with stop bit clear");
   AST_NO_CONTINUOUS_ENABLE: assert property (@(posedge clk) disable iff (!nrst) // [RULE_13]
      !evt_in.continuous_enable |=> !go_clear_q && !retrigger_q)
      else $error("go action without continuous mode");
   AST_ERR_EVERY: assert property (@(posedge clk) disable iff (!nrst) // [RULE_10]
      (evt_in.conv_done && evt_in.double_sample_enable && previous_source_select && error_sel_a_defined) |=> ##1 error_valid_q)
      else $error("error not computed on every sample");
   AST_PREV_FLT: assert property (@(posedge clk) disable iff (!nrst) // [RULE_14]
      (evt_in.conv_start && previous_source_select) |=> previous_result_q == $past(data_in.filtered_value))
      else $error("filtered value not captured as previous");
endmodule : acc_ctrl
`default_nettype wire

// File: verilog/acc_pkg.sv
// Purpose: shared constants and types for the computation control block
// Assumes: byte registers on a plain port, 250 MHz clock
// Notes:   offsets are register indices on the plain port
package acc_pkg;
   localparam logic [15:0] ACC_CTRL_A_OFS   = 16'h1D28;
   localparam logic [15:0] ACC_CTRL_B_OFS   = 16'h1D29;
   localparam logic [7:0]  ACC_CTRL_A_RST   = 8'h00;
   localparam logic [7:0]  ACC_CTRL_B_RST   = 8'h00;
   localparam int          ACC_MODE_LSB     = 0;
   localparam int          ACC_CLR_BIT      = 3;
   localparam int          ACC_SHIFT_LSB    = 4;
   localparam int          ACC_PREVIOUS_SOURCE_SELECT_BIT     = 7;
   localparam int          ACC_TMD_LSB      = 0;
   localparam int          ACC_SOI_BIT      = 3;
   localparam int          ACC_ERROR_SEL_A_LSB     = 4;
   localparam int          ACC_DW           = 16;
   localparam int          ACC_AW           = 18;
   localparam logic [3:0]  ACC_CLR_CYCLES   = 4'h4;

   typedef enum logic [2:0] {
      ACC_MD_BASIC = 3'b000,
      ACC_MD_ACCUM = 3'b001,
      ACC_MD_AVG   = 3'b010,
      ACC_MD_BURST = 3'b011,
      ACC_MD_LPF   = 3'b100
   } acc_mode_e;

   typedef enum logic [2:0] {
      ACC_ERROR_SEL_A_RES_PREV  = 3'b000,
      ACC_ERROR_SEL_A_RES_STPT  = 3'b001,
      ACC_ERROR_SEL_A_RES_FLT   = 3'b010,
      ACC_ERROR_SEL_A_PREV_FLT  = 3'b100,
      ACC_ERROR_SEL_A_FLT_STPT  = 3'b101
   } acc_error_sel_a_e;

   typedef struct packed {
      logic [ACC_DW-1:0] conversion_result;
      logic [ACC_DW-1:0] filtered_value;
      logic [ACC_DW-1:0] setpoint_value;
   } acc_data_s;

   typedef struct packed {
      logic conv_start;
      logic conv_done;
      logic threshold_met;
      logic continuous_enable;
      logic double_sample_enable;
   } acc_evt_s;
endpackage : acc_pkg

// File: verilog/acc_subtract.sv
// Purpose: registered signed difference of three operands, a - b - c
// Assumes: inputs synchronous to clk
// Notes:   result valid one cycle after en
`timescale 1ns/1ps
`default_nettype none
module acc_subtract
   import acc_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // operands
   input  wire logic              en,
   input  wire logic [ACC_DW-1:0] a,
   input  wire logic [ACC_DW-1:0] b,
   input  wire logic [ACC_DW-1:0] c,
   // result
   output logic      [ACC_DW:0]   diff_q
);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         diff_q <= '0;
      end else if (en) begin
         diff_q <= {1'b0, a} - {1'b0, b} - {1'b0, c};
      end
   end
endmodule : acc_subtract
`default_nettype wire

// File: verification/tb_acc_ctrl.sv
// Purpose: self-checking bench for the computation control block
// Assumes: 250 MHz clock, register port with read data one cycle after the read strobe
// Notes:   random stimulus from a fixed seed, corner cases written by hand
`timescale 1ns/1ps
`default_nettype none
module tb_acc_ctrl
   import acc_pkg::*;
;
   logic              clk;
   logic              nrst;
   logic [15:0]       reg_addr;
   logic [7:0]        reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   wire logic [7:0]   reg_rdata_q;
   acc_data_s         data_in;
   acc_evt_s          evt_in;
   logic [ACC_AW-1:0] accum_raw;
   wire logic [ACC_AW-1:0] accumulator_value_q;
   wire logic [ACC_DW-1:0] previous_result_q;
   wire logic [ACC_DW:0]   error_value_q;
   wire logic              error_valid_q;
   wire logic              accum_clear_q;
   wire logic              go_clear_q;
   wire logic              retrigger_q;
   wire logic [2:0]        operating_mode_q;
   int                errors;
   int                tests_run;

   acc_ctrl dut_u (
      .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .data_in(data_in), .evt_in(evt_in),
      .accum_raw(accum_raw), .accumulator_value_q(accumulator_value_q),
      .previous_result_q(previous_result_q), .error_value_q(error_value_q),
      .error_valid_q(error_valid_q), .accum_clear_q(accum_clear_q), .go_clear_q(go_clear_q),
      .retrigger_q(retrigger_q), .operating_mode_q(operating_mode_q)
   );

   always #2 clk = ~clk;

   // ----------------------------------------------------------------
   // bench tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata_q;
   endtask : rd

   // pulse a conversion-done and watch the answers for six cycles
   task automatic done_pulse(output logic v, output logic [16:0] e, output logic gc, output logic rt);
      v  = 1'b0;
      gc = 1'b0;
      rt = 1'b0;
      e  = '0;
      @(posedge clk);
      evt_in.conv_done <= 1'b1;
      @(posedge clk);
      evt_in.conv_done <= 1'b0;
      repeat (6) begin
         #1;
         if (error_valid_q === 1'b1) begin
            v = 1'b1;
            e = error_value_q;
         end
         gc |= (go_clear_q === 1'b1);
         rt |= (retrigger_q === 1'b1);
         @(posedge clk);
      end
   endtask : done_pulse

   function automatic logic [16:0] exp_err(input logic [2:0] c, input logic ds, input acc_data_s d,
                                           input logic [15:0] p);
      case (c)
         3'h0:    return {1'b0, d.conversion_result} - {1'b0, p};
         3'h1:    return ds ? {1'b0, d.conversion_result} - {1'b0, p} - {1'b0, d.setpoint_value}
                            : {1'b0, d.conversion_result} - {1'b0, d.setpoint_value};
         3'h2:    return ds ? {1'b0, d.conversion_result} - {1'b0, p} - {1'b0, d.filtered_value}
                            : {1'b0, d.conversion_result} - {1'b0, d.filtered_value};
         3'h4:    return {1'b0, p} - {1'b0, d.filtered_value};
         default: return {1'b0, d.filtered_value} - {1'b0, d.setpoint_value};
      endcase
   endfunction : exp_err

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0]  d;
      logic [7:0]  v8;
      logic        v;
      logic        gc;
      logic        rt;
      logic        ps;
      logic [16:0] e;
      logic [15:0] pv;
      int          n;
      clk = 1'b0; nrst = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
      data_in = '0; evt_in = '0; accum_raw = '0; errors = 0; tests_run = 0;
      void'($urandom(32'h2B11));
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      rd(ACC_CTRL_A_OFS, d); chk("ctrl a reset", ACC_CTRL_A_RST, d);
      rd(ACC_CTRL_B_OFS, d); chk("ctrl b reset", ACC_CTRL_B_RST, d);
      rd(16'h1D2F, d); chk("unmapped read", 8'h00, d);
      v8 = 8'($urandom()) & 8'h7F;
      wr(ACC_CTRL_B_OFS, v8 | 8'h80); rd(ACC_CTRL_B_OFS, d); chk("ctrl b rw", v8, d);
      // shift and mode for every mode code, shift values kept legal
      for (int m = 0; m < 8; m++) begin
         for (int s = 1; s < 7; s++) begin
            @(posedge clk);
            accum_raw <= ACC_AW'($urandom());
            wr(ACC_CTRL_A_OFS, {1'b0, 3'(s), 1'b0, 3'(m)});
            repeat (3) @(posedge clk);
            #1 chk("mode out", (m < 5) ? m : 0, operating_mode_q);
            chk("accum", (m inside {1, 2, 3}) ? accum_raw >> s : accum_raw, accumulator_value_q);
         end
      end
      rd(ACC_CTRL_A_OFS, d); chk("ctrl a rw", {1'b0, 3'h6, 1'b0, 3'h7}, d);
      // clear: bit reads high while busy, accumulator held at zero, bit drops when done
      accum_raw <= 18'h3FFFF;
      wr(ACC_CTRL_A_OFS, 8'h2B);
      rd(ACC_CTRL_A_OFS, d); chk("clear bit busy", 8'h2B, d);
      chk("accum clearing", 0, accumulator_value_q);
      wr(ACC_CTRL_A_OFS, 8'h2B);
      // the restarted clear is already high as the write returns
      #1 n = (accum_clear_q === 1'b1);
      repeat (10) begin
         @(posedge clk);
         #1 n += (accum_clear_q === 1'b1);
      end
      chk("clear length", ACC_CLR_CYCLES, n);
      rd(ACC_CTRL_A_OFS, d); chk("clear bit done", 8'h23, d);
      // error selection, single and double sample, every code
      for (int ds = 0; ds < 2; ds++) begin
         for (int c = 0; c < 8; c++) begin
            ps = ds[0] ? 1'b1 : 1'($urandom());
            evt_in.double_sample_enable <= ds[0];
            data_in <= acc_data_s'({$urandom(), $urandom()});
            wr(ACC_CTRL_A_OFS, {ps, 7'h00});
            wr(ACC_CTRL_B_OFS, {1'b0, 3'(c), 4'h0});
            @(posedge clk);
            evt_in.conv_start <= 1'b1;
            @(posedge clk);
            evt_in.conv_start <= 1'b0;
            repeat (3) @(posedge clk);
            #1 pv = ps ? data_in.filtered_value : data_in.conversion_result;
            chk("previous", pv, previous_result_q);
            done_pulse(v, e, gc, rt);
            chk("err valid", c inside {0, 1, 2, 4, 5}, v);
            if (v) chk("err value", exp_err(3'(c), ds[0], data_in, pv), e);
            chk("no go action", 0, {gc, rt});
         end
      end
      // double sample, source select clear: error only after the second sample
      evt_in.double_sample_enable <= 1'b0;
      wr(ACC_CTRL_A_OFS, 8'h00);
      wr(ACC_CTRL_B_OFS, 8'h10);
      evt_in.double_sample_enable <= 1'b1;
      repeat (2) @(posedge clk);
      done_pulse(v, e, gc, rt); chk("pair first", 0, v);
      done_pulse(v, e, gc, rt); chk("pair second", 1, v);
      chk("pair value", exp_err(3'h1, 1'b1, data_in, pv), e);
      evt_in.double_sample_enable <= 1'b0;
      // stop on threshold against continuous mode, all combinations
      for (int k = 0; k < 8; k++) begin
         evt_in.continuous_enable <= k[2];
         evt_in.threshold_met     <= k[0];
         wr(ACC_CTRL_B_OFS, {4'h0, k[1], 3'($urandom())});
         done_pulse(v, e, gc, rt);
         chk("go clear", k[2] & k[1] & k[0], gc);
         chk("retrigger", k[2] & ~(k[1] & k[0]), rt);
      end
      // reset in mid-run returns the registers to zero
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(ACC_CTRL_B_OFS, d); chk("ctrl b after reset", ACC_CTRL_B_RST, d);
      stop_test();
   end

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   initial begin
      #200000;
      errors++;
      $display("FAIL watchdog expected end seen hang");
      stop_test();
   end
endmodule : tb_acc_ctrl
`default_nettype wire
